//--- design/sim_regs.svh
// Register offsets, field positions, reset values and timing counts of the input monitor
`ifndef SIM_REGS_SVH
`define SIM_REGS_SVH
`define SIM_CLK_HZ 20000000
`define SIM_TICK_S 1
`define SIM_TICK_W 25
`define SIM_PIN_W 14
`define SIM_PIN_SINGLE 0
`define SIM_PIN_STATIC 1
`define SIM_PIN_DEP_A 2
`define SIM_PIN_DEP_B 3
`define SIM_PIN_IND_A 4
`define SIM_PIN_IND_B 5
`define SIM_PIN_SEL_LO 6
`define SIM_SEL_W 8
`define SIM_POS_MIN 4'h2
`define SIM_POS_MAX 4'h8
`define SIM_ADR_CONFIG 4'h0
`define SIM_ADR_STATUS 4'h4
`define SIM_ADR_IRQ_ST 4'h8
`define SIM_ADR_IRQ_MASK 4'hc
`define SIM_CFG_DEP_NONC 0
`define SIM_CFG_IND_NONC 1
`define SIM_CFG_POS_LO 4
`define SIM_CFG_POS_HI 7
`define SIM_CFG_LIM_LO 8
`define SIM_CFG_LIM_HI 15
`define SIM_CFG_RESET 32'h0000_0380
`define SIM_CFG_MASK 32'h0000_fff3
`define SIM_IRQ_W 4
`define SIM_MASK_RESET 4'h0
`endif

//--- design/sim_pkg.sv
// Types shared by the input monitor and its users
package sim_pkg;
  // Bit order matches the status register, bit 0 first from the right
  typedef struct packed {
    logic [3:0] sel_code;
    logic sel_err;
    logic ind_err;
    logic ind_out;
    logic dep_err;
    logic dep_out;
    logic static_out;
    logic single_err;
    logic single_out;
  } mon_status_t;
  typedef enum logic [1:0] {DEP_AGREE, DEP_TIMING, DEP_LOCKED} dep_state_t;
endpackage

//--- design/safety_input_monitor.sv
// Input monitors for contacts, static signals, contact pairs and a mode selector
//
// Implementation choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "sim_regs.svh"

module safety_input_monitor #(
  parameter int TICK_CYCLES = `SIM_CLK_HZ * `SIM_TICK_S // Cycles per second tick
) (
  input wire logic SYS_CLK_I, // Module clock, 20 MHz
  input wire logic RESET_N_I, // Asynchronous reset, active low
  input wire logic [`SIM_PIN_W-1:0] PIN_I, // Contact and selector pins, high = closed
  input wire logic [`SIM_PIN_W-1:0] FAULT_I, // Electrical fault report per pin
  input wire logic WB_CYC_I, // Wishbone cycle
  input wire logic WB_STB_I, // Wishbone strobe
  input wire logic WB_WE_I, // Wishbone write enable
  input wire logic [3:0] WB_SEL_I, // Wishbone byte selects
  input wire logic [3:0] WB_ADR_I, // Wishbone byte address
  input wire logic [31:0] WB_DAT_I, // Wishbone write data
  output logic [31:0] WB_DAT_O, // Wishbone read data
  output logic WB_ACK_O, // Wishbone acknowledge
  output sim_pkg::mon_status_t MON_O, // Monitor outputs
  output logic IRQ_O // Interrupt, high while an unmasked event is pending
);
  import sim_pkg::*;

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  // ==========================================================
  // Functions
  function automatic logic [3:0] pos_clamp(input logic [3:0] n);
    if (n < `SIM_POS_MIN) begin
      pos_clamp = `SIM_POS_MIN;
    end else if (n > `SIM_POS_MAX) begin
      pos_clamp = `SIM_POS_MAX;
    end else begin
      pos_clamp = n;
    end
  endfunction

  function automatic logic [7:0] pos_mask(input logic [3:0] n);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < `SIM_SEL_W; i++) begin
      if (i < int'(n)) begin
        m[i] = 1'b1;
      end
    end
    pos_mask = m;
  endfunction

  function automatic logic [3:0] pos_code(input logic [7:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < `SIM_SEL_W; i++) begin
      if (v[i]) begin
        c = 4'(i + 1);
      end
    end
    pos_code = c;
  endfunction

  // ==========================================================
  // Input synchronisers
  logic [`SIM_PIN_W-1:0] s1_reg;
  logic [`SIM_PIN_W-1:0] s2_reg;
  logic [`SIM_PIN_W-1:0] s3_reg;
  logic [`SIM_PIN_W-1:0] flt_reg;

  genvar g;
  generate
    for (g = 0; g < `SIM_PIN_W; g++) begin : g_sync
      always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
          s1_reg[g] <= 1'b0;
          s2_reg[g] <= 1'b0;
          s3_reg[g] <= 1'b0;
          flt_reg[g] <= 1'b0;
        end else begin
          s1_reg[g] <= PIN_I[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          if (s2_reg[g] == s3_reg[g]) begin
            flt_reg[g] <= s3_reg[g];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Configuration
  logic [31:0] cfg_reg;
  logic dep_nonc;
  logic ind_nonc;
  logic [3:0] pos_cnt;
  logic [7:0] sim_limit;

  assign dep_nonc = cfg_reg[`SIM_CFG_DEP_NONC];
  assign ind_nonc = cfg_reg[`SIM_CFG_IND_NONC];
  assign pos_cnt = pos_clamp(cfg_reg[`SIM_CFG_POS_HI:`SIM_CFG_POS_LO]);
  assign sim_limit = cfg_reg[`SIM_CFG_LIM_HI:`SIM_CFG_LIM_LO];

  // ==========================================================
  // Dependent pair simultaneity timer
  dep_state_t dep_state_reg;
  logic [`SIM_TICK_W-1:0] tick_reg;
  logic [7:0] sec_reg;
  logic dep_a;
  logic dep_b;

  assign dep_a = flt_reg[`SIM_PIN_DEP_A];
  assign dep_b = flt_reg[`SIM_PIN_DEP_B] ^ dep_nonc;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      dep_state_reg <= DEP_AGREE;
    end else begin
      case (dep_state_reg)
        DEP_AGREE: begin
          if (dep_a != dep_b) begin
            dep_state_reg <= DEP_TIMING;
          end
        end
        DEP_TIMING: begin
          if (dep_a == dep_b) begin
            dep_state_reg <= DEP_AGREE;
          end else if (sec_reg >= sim_limit) begin
            dep_state_reg <= DEP_LOCKED;
          end
        end
        DEP_LOCKED: begin
          // Held until both contacts are back in the tripped state
          if (!dep_a && !dep_b) begin
            dep_state_reg <= DEP_AGREE;
          end
        end
        default: begin
          dep_state_reg <= DEP_AGREE;
        end
      endcase
    end
  end

  // Prescaler restarts at the first change so whole seconds are counted
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tick_reg <= '0;
      sec_reg <= 8'h00;
    end else if (dep_state_reg != DEP_TIMING) begin
      tick_reg <= '0;
      sec_reg <= 8'h00;
    end else if (tick_reg == `SIM_TICK_W'(TICK_CYCLES - 1)) begin
      tick_reg <= '0;
      if (sec_reg != 8'hff) begin
        sec_reg <= sec_reg + 8'h01;
      end
    end else begin
      tick_reg <= tick_reg + `SIM_TICK_W'(1);
    end
  end

  a_dep_timer_bound: assert property (
    dep_state_reg == DEP_TIMING && $stable(sim_limit) |-> sec_reg <= sim_limit)
    else $error("simultaneity seconds passed the limit");

  // ==========================================================
  // Monitor outputs
  mon_status_t mon_next;
  mon_status_t mon_reg;
  logic [7:0] sel_act;
  logic [7:0] sel_m;
  logic sel_one;
  logic ind_b;

  assign sel_m = pos_mask(pos_cnt);
  assign sel_act = flt_reg[`SIM_PIN_SEL_LO +: `SIM_SEL_W] & sel_m;
  assign sel_one = (sel_act != 8'h00) && ((sel_act & (sel_act - 8'h01)) == 8'h00);
  assign ind_b = flt_reg[`SIM_PIN_IND_B] ^ ind_nonc;

  always_comb begin
    mon_next.single_err = FAULT_I[`SIM_PIN_SINGLE];
    mon_next.single_out = flt_reg[`SIM_PIN_SINGLE] & ~FAULT_I[`SIM_PIN_SINGLE];
    mon_next.static_out = flt_reg[`SIM_PIN_STATIC];
    mon_next.dep_err = (dep_state_reg == DEP_LOCKED)
      | FAULT_I[`SIM_PIN_DEP_A] | FAULT_I[`SIM_PIN_DEP_B];
    mon_next.dep_out = dep_a & dep_b & ~mon_next.dep_err;
    mon_next.ind_err = FAULT_I[`SIM_PIN_IND_A] | FAULT_I[`SIM_PIN_IND_B];
    mon_next.ind_out = flt_reg[`SIM_PIN_IND_A] & ind_b & ~mon_next.ind_err;
    mon_next.sel_err = ~sel_one
      | (|(FAULT_I[`SIM_PIN_SEL_LO +: `SIM_SEL_W] & sel_m));
    mon_next.sel_code = mon_next.sel_err ? 4'h0 : pos_code(sel_act);
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mon_reg <= '0;
    end else begin
      mon_reg <= mon_next;
    end
  end

  assign MON_O = mon_reg;

  a_single_out_ok: assert property (
    flt_reg[`SIM_PIN_SINGLE] && !FAULT_I[`SIM_PIN_SINGLE] |=> MON_O.single_out)
    else $error("single contact status missing");
  a_single_err_set: assert property (FAULT_I[`SIM_PIN_SINGLE] |=> MON_O.single_err)
    else $error("single contact error missing");
  a_static_follow: assert property (##1 MON_O.static_out == $past(flt_reg[`SIM_PIN_STATIC]))
    else $error("static status does not follow input");
  a_dep_out_clean: assert property (MON_O.dep_out |-> !MON_O.dep_err && $past(dep_a))
    else $error("dependent status with error or open contact");
  a_dep_timeout: assert property (
    dep_state_reg == DEP_TIMING && dep_a != dep_b && sec_reg >= sim_limit |=> ##1 MON_O.dep_err)
    else $error("simultaneity timeout not flagged");
  a_dep_fault: assert property (
    FAULT_I[`SIM_PIN_DEP_A] || FAULT_I[`SIM_PIN_DEP_B] |=> MON_O.dep_err)
    else $error("dependent fault not flagged");
  a_ind_err_only: assert property (
    ##1 MON_O.ind_err == $past(FAULT_I[`SIM_PIN_IND_A] | FAULT_I[`SIM_PIN_IND_B]))
    else $error("independent error not tied to fault");
  a_ind_out_clean: assert property (MON_O.ind_out |-> !MON_O.ind_err)
    else $error("independent status with error");
  a_sel_code_zero: assert property (MON_O.sel_err |-> MON_O.sel_code == 4'h0)
    else $error("selector code not zero on error");
  a_sel_none: assert property (RESET_N_I && sel_act == 8'h00 |=> MON_O.sel_err)
    else $error("selector with no input not flagged");
  a_sel_range: assert property (
    $past(RESET_N_I) && !MON_O.sel_err
      |-> MON_O.sel_code >= 4'h1 && MON_O.sel_code <= $past(pos_cnt))
    else $error("selector code out of range");

  c_dep_locked: cover property (dep_state_reg == DEP_TIMING ##1 dep_state_reg == DEP_LOCKED);
  c_dep_out: cover property (MON_O.dep_out);
  c_sel_top: cover property (MON_O.sel_code == 4'h8);

  // ==========================================================
  // Interrupts
  logic [`SIM_IRQ_W-1:0] err_now;
  logic [`SIM_IRQ_W-1:0] err_new;
  logic [`SIM_IRQ_W-1:0] irq_st_reg;
  logic [`SIM_IRQ_W-1:0] irq_mask_reg;
  logic rd_irq;

  assign err_now = {mon_reg.sel_err, mon_reg.ind_err, mon_reg.dep_err, mon_reg.single_err};
  assign err_new = {mon_next.sel_err, mon_next.ind_err, mon_next.dep_err, mon_next.single_err};

  // Set wins over the clear of a same-cycle read
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      irq_st_reg <= '0;
    end else begin
      irq_st_reg <= (irq_st_reg & ~{`SIM_IRQ_W{rd_irq}}) | (err_new & ~err_now);
    end
  end

  assign IRQ_O = |(irq_st_reg & irq_mask_reg);

  a_irq_level: assert property (
    |(err_new & ~err_now & irq_mask_reg) && !(req && WB_WE_I) |=> IRQ_O)
    else $error("unmasked event did not raise the interrupt");
  c_irq: cover property (IRQ_O);

  // ==========================================================
  // Wishbone slave
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic req;
  logic [3:0] badr;
  logic [31:0] wmask;

  assign req = WB_CYC_I & WB_STB_I & ~ack_reg;
  assign badr = {WB_ADR_I[3:2], 2'b00};
  assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign rd_irq = req & ~WB_WE_I & (badr == `SIM_ADR_IRQ_ST);

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cfg_reg <= `SIM_CFG_RESET;
      irq_mask_reg <= `SIM_MASK_RESET;
    end else if (req && WB_WE_I) begin
      if (badr == `SIM_ADR_CONFIG) begin
        cfg_reg <= ((cfg_reg & ~wmask) | (WB_DAT_I & wmask)) & `SIM_CFG_MASK;
      end
      if (badr == `SIM_ADR_IRQ_MASK && WB_SEL_I[0]) begin
        irq_mask_reg <= WB_DAT_I[`SIM_IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rdat_reg <= 32'h0000_0000;
    end else if (req && !WB_WE_I) begin
      case (badr)
        `SIM_ADR_CONFIG: rdat_reg <= cfg_reg;
        `SIM_ADR_STATUS: rdat_reg <= {20'h0_0000, mon_reg};
        `SIM_ADR_IRQ_ST: rdat_reg <= {28'h000_0000, irq_st_reg};
        `SIM_ADR_IRQ_MASK: rdat_reg <= {28'h000_0000, irq_mask_reg};
        default: rdat_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdat_reg;

  a_wb_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held for two cycles");
endmodule // safety_input_monitor

//--- test/contact_field.sv
// Behavioural contacts, sensors and selector that drive the monitor pins
`timescale 1ns/1ps
module contact_field (
  input wire logic clk_i, // Module clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic [13:0] closed_i, // Wanted contact positions, high = closed
  input wire logic [13:0] fault_i, // Injected electrical faults
  input wire logic [7:0] skew_i, // Lag of the second linked contact in cycles
  output logic [13:0] pin_o, // Contact levels
  output logic [13:0] fault_o // Fault reports
);
  logic [7:0] lag_reg;
  // ==================================================
  // Contacts; the second linked contact trails the first
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o <= '0;
      lag_reg <= 8'h00;
    end else begin
      pin_o[2:0] <= closed_i[2:0];
      pin_o[13:4] <= closed_i[13:4];
      if (closed_i[3] == pin_o[3]) begin
        lag_reg <= 8'h00;
      end else if (lag_reg >= skew_i) begin
        pin_o[3] <= closed_i[3];
      end else begin
        lag_reg <= lag_reg + 8'h01;
      end
    end
  end
  // ==================================================
  // Electrical fault reports
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_o <= '0;
    end else begin
      fault_o <= fault_i;
    end
  end
endmodule // contact_field

//--- test/safety_input_monitor_tb.sv
// Self-checking bench for the safety input monitor
`timescale 1ns/1ps
`include "sim_regs.svh"
module safety_input_monitor_tb;
  import sim_pkg::*;
  localparam int TICK = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack;
  logic irq;
  logic [13:0] closed = 14'h0;
  logic [13:0] flt = 14'h0;
  logic [13:0] pin;
  logic [13:0] fault;
  logic [7:0] skew = 8'h00;
  mon_status_t mon;
  int num_errors = 0;
  int comparisons = 0;
  always #25 clk = ~clk;
  contact_field i_contact_field (.clk_i(clk), .rst_n_i(rst_n), .closed_i(closed),
    .fault_i(flt), .skew_i(skew), .pin_o(pin), .fault_o(fault));
  safety_input_monitor #(.TICK_CYCLES(TICK)) i_safety_input_monitor (.SYS_CLK_I(clk),
    .RESET_N_I(rst_n), .PIN_I(pin), .FAULT_I(fault), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_SEL_I(sel), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .MON_O(mon), .IRQ_O(irq));
  // ==================================================
  // Tasks
  task final_report;
    $display("Errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task drive(input logic [13:0] c, input logic [13:0] f, input int n);
    @(posedge clk);
    closed <= c;
    flt <= f;
    repeat (n) @(posedge clk);
  endtask
  // ==================================================
  // Tests
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, `SIM_ADR_CONFIG, 32'h0);
    chk(rd, 32'h0000_0380);
    wb(1'b0, `SIM_ADR_IRQ_ST, 32'h0);
    chk(rd[3], 1'b1);
    wb(1'b1, `SIM_ADR_IRQ_MASK, 32'hf);
    wb(1'b1, `SIM_ADR_CONFIG, 32'h0000_0280);
    drive(14'h0003, 14'h0, 8);
    chk(mon.single_out, 1);
    chk(mon.single_err, 0);
    chk(mon.static_out, 1);
    drive(14'h0003, 14'h0001, 3);
    chk(mon.single_err, 1);
    chk(mon.single_out, 0);
    chk(irq, 1);
    wb(1'b0, `SIM_ADR_IRQ_ST, 32'h0);
    chk(rd[3:0], 4'h1);
    chk(irq, 0);
    drive(14'h0030, 14'h0, 8);
    chk(mon.ind_out, 1);
    chk(mon.single_out, 0);
    chk(mon.static_out, 0);
    drive(14'h0010, 14'h0, 40);
    chk(mon.ind_out, 0);
    chk(mon.ind_err, 0);
    drive(14'h0010, 14'h0020, 3);
    chk(mon.ind_err, 1);
    wb(1'b1, `SIM_ADR_CONFIG, 32'h0000_0282);
    drive(14'h0010, 14'h0, 8);
    chk(mon.ind_out, 1);
    skew <= 8'd3;
    drive(14'h000c, 14'h0, 16);
    chk(mon.dep_out, 1);
    chk(mon.dep_err, 0);
    skew <= 8'd60;
    drive(14'h0, 14'h0, 14);
    chk(mon.dep_err, 0);
    repeat (31) @(posedge clk);
    chk(mon.dep_err, 1);
    chk(mon.dep_out, 0);
    repeat (45) @(posedge clk);
    chk(mon.dep_err, 0);
    drive(14'h0, 14'h0008, 3);
    chk(mon.dep_err, 1);
    skew <= 8'd0;
    drive(14'h0, 14'h0, 3);
    wb(1'b1, `SIM_ADR_CONFIG, 32'h0000_0283);
    drive(14'h0004, 14'h0, 10);
    chk(mon.dep_out, 1);
    wb(1'b1, `SIM_ADR_IRQ_MASK, 32'h0);
    chk(irq, 0);
    wb(1'b1, `SIM_ADR_IRQ_MASK, 32'h2);
    chk(irq, 1);
    wb(1'b0, `SIM_ADR_IRQ_ST, 32'h0);
    chk(rd[1], 1'b1);
    chk(irq, 0);
    for (int i = 0; i < 8; i++) begin
      drive(14'h0040 << i, 14'h0, 8);
      chk(mon.sel_code, i + 1);
      chk(mon.sel_err, 0);
    end
    drive(14'h00c0, 14'h0, 8);
    chk(mon.sel_err, 1);
    chk(mon.sel_code, 0);
    drive(14'h0, 14'h0, 8);
    chk(mon.sel_err, 1);
    wb(1'b1, `SIM_ADR_CONFIG, 32'h0000_0233);
    drive(14'h0800, 14'h0, 8);
    chk(mon.sel_err, 1);
    drive(14'h0880, 14'h0, 8);
    chk(mon.sel_code, 2);
    wb(1'b0, `SIM_ADR_STATUS, 32'h0);
    chk(rd[11:7], 5'h04);
    drive(14'h0880, 14'h0080, 3);
    chk(mon.sel_err, 1);
    chk(mon.sel_code, 0);
    final_report;
  end
  // ==================================================
  // Watchdog
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    final_report;
  end
endmodule // safety_input_monitor_tb
